// ---- rtl/ceh_defs.svh ----
`ifndef CEH_DEFS_SVH
`define CEH_DEFS_SVH

// clock and bit timing
`define CEH_CLK_PERIOD_NS 4
`define CEH_BIT_TIME_NS   1000
`define CEH_BIT_CYCLES    (`CEH_BIT_TIME_NS / `CEH_CLK_PERIOD_NS)

// bus levels
`define CEH_DOMINANT      1'b0
`define CEH_RECESSIVE     1'b1

// fixed sequence lengths
`define CEH_FLAG_LAST     3'h5
`define CEH_DELIM_LAST    3'h6
`define CEH_STUFF_RUN     3'h5
`define CEH_IDLE_LAST     4'ha
`define CEH_RECOVER_LAST  8'h7f

// fault confinement
`define CEH_PASSIVE_LIMIT 9'h07f
`define CEH_TX_ERR_STEP   9'h008
`define CEH_TX_OK_STEP    9'h001
`define CEH_RX_ERR_STEP   8'h01
`define CEH_RX_OK_STEP    8'h01
`define CEH_REC_MAX       8'hff

// crc
`define CEH_CRC_POLY      15'h4599
`define CEH_CRC_LAST      4'he

`endif

// ---- rtl/ceh_pkg.sv ----
package ceh_pkg;

	typedef enum logic [2:0] {
		F_IDLE,
		F_STUFFED,
		F_CRC,
		F_CRCDEL,
		F_ACK,
		F_ACKDEL,
		F_EOF
	} ceh_field_type;

	typedef enum logic [1:0] {
		ERR_ACTIVE,
		ERR_PASSIVE,
		BUS_OFF
	} ceh_node_type;

	typedef enum logic [1:0] {
		SIG_IDLE,
		SIG_FLAG,
		SIG_WAIT,
		SIG_DELIM
	} ceh_sig_type;

endpackage : ceh_pkg

// ---- rtl/ceh_crc15.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ceh_defs.svh"

module ceh_crc15 (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        clear,
	input  wire logic        shift,
	input  wire logic        din,
	output var  logic [14:0] crc
);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			crc <= 15'h0000;
		end else if (clear) begin
			crc <= 15'h0000;
		end else if (shift) begin
			crc <= {crc[13:0], 1'b0} ^ ((din ^ crc[14]) ? `CEH_CRC_POLY : 15'h0000);
		end
	end

endmodule : ceh_crc15

`default_nettype wire

// ---- rtl/ceh_core.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ceh_defs.svh"

module ceh_core
	import ceh_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          reset_n,
	input  wire logic          canRx,
	output var  logic          canTx,
	input  wire logic          txMode,
	input  wire ceh_field_type fieldIn,
	input  wire logic          txData,
	input  wire logic          ackEn,
	output var  logic          bitStep,
	output var  logic          rxValid,
	output var  logic          rxBit,
	output var  logic          errPulse,
	output var  logic          txOk,
	output var  logic          rxOk,
	output var  logic          busReady,
	output var  ceh_node_type  nodeState,
	output var  logic [8:0]    txErrCount,
	output var  logic [7:0]    rxErrCount
);

	logic          rxMeta_q;
	logic          rxSync_q;
	logic [7:0]    divCnt_q;
	logic          tick_q;
	ceh_field_type curField_q;
	logic          curStuff_q;
	logic          curDrive_q;
	logic [2:0]    runCnt_q;
	logic          runLast_q;
	logic [3:0]    crcIdx_q;
	ceh_sig_type   sigState_q;
	logic [2:0]    sigCnt_q;
	logic          flagDom_q;
	ceh_node_type  node_q;
	logic [8:0]    tec_q;
	logic [7:0]    rec_q;
	logic [3:0]    idleRun_q;
	logic [7:0]    recoverCnt_q;
	logic          canTx_q;
	logic          bitStep_q;
	logic          rxValid_q;
	logic          rxBit_q;
	logic          errPulse_q;
	logic          txOk_q;
	logic          rxOk_q;
	logic          busReady_q;
	logic [14:0]   txCrc;
	logic [14:0]   rxCrc;
	logic [2:0]    runNext;
	logic          normalTick;
	logic          bitErr;
	logic          stuffErr;
	logic          crcErr;
	logic          formErr;
	logic          ackErr;
	logic          errNow;
	logic          nextStuff;
	logic          driveBit;
	logic          frameEnd;
	logic          recoverDone;
	logic [3:0]    crcPos;

	function automatic logic isStuffed(input ceh_field_type f);
		return (f == F_STUFFED) || (f == F_CRC);
	endfunction : isStuffed

	// pin synchroniser and bit-rate divider
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxMeta_q <= `CEH_RECESSIVE;
			rxSync_q <= `CEH_RECESSIVE;
		end else begin
			rxMeta_q <= canRx;
			rxSync_q <= rxMeta_q;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCnt_q <= 8'h00;
			tick_q   <= 1'b0;
		end else begin
			tick_q <= (divCnt_q == 8'(`CEH_BIT_CYCLES - 1));
			if (divCnt_q == 8'(`CEH_BIT_CYCLES - 1)) begin
				divCnt_q <= 8'h00;
			end else begin
				divCnt_q <= divCnt_q + 8'h01;
			end
		end
	end

	ceh_crc15 u_tx_crc (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.clear   (tick_q && (fieldIn == F_IDLE)),
		.shift   (normalTick && !errNow && !nextStuff && fieldIn == F_STUFFED),
		.din     (txData),
		.crc     (txCrc)
	);

	ceh_crc15 u_rx_crc (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.clear   (tick_q && (curField_q == F_IDLE)),
		.shift   (normalTick && !curStuff_q && isStuffed(curField_q)),
		.din     (rxSync_q),
		.crc     (rxCrc)
	);

	// error detection on the sampled bit
	always_comb begin
		normalTick = tick_q && (sigState_q == SIG_IDLE) && (node_q != BUS_OFF);
		runNext = 3'h1;
		if (runCnt_q != 3'h0 && rxSync_q == runLast_q) begin
			runNext = runCnt_q + 3'h1;
		end
		bitErr   = txMode && (rxSync_q != curDrive_q) && (curField_q != F_ACK);
		stuffErr = curStuff_q && (rxSync_q == runLast_q);
		crcErr   = !txMode && (curField_q == F_CRCDEL) && (rxCrc != 15'h0000);
		formErr  = ((curField_q == F_CRCDEL) || (curField_q == F_ACKDEL) ||
			(curField_q == F_EOF)) && (rxSync_q == `CEH_DOMINANT);
		ackErr   = txMode && (curField_q == F_ACK) && (rxSync_q == `CEH_RECESSIVE);
		errNow   = normalTick && (curField_q != F_IDLE) &&
			(bitErr || stuffErr || crcErr || formErr || ackErr);
		nextStuff = isStuffed(fieldIn) && isStuffed(curField_q) &&
			(runNext == `CEH_STUFF_RUN);
		frameEnd = normalTick && !errNow && (curField_q == F_EOF) && (fieldIn != F_EOF);
		recoverDone = tick_q && (node_q == BUS_OFF) && (rxSync_q == `CEH_RECESSIVE) &&
			(idleRun_q == `CEH_IDLE_LAST) && (recoverCnt_q == `CEH_RECOVER_LAST);
		crcPos = `CEH_CRC_LAST - crcIdx_q;
		unique case (fieldIn)
			F_STUFFED: driveBit = txMode ? txData : `CEH_RECESSIVE;
			F_CRC:     driveBit = txMode ? txCrc[crcPos] : `CEH_RECESSIVE;
			F_ACK:     driveBit = (!txMode && ackEn) ? `CEH_DOMINANT : `CEH_RECESSIVE;
			F_IDLE, F_CRCDEL, F_ACKDEL, F_EOF: driveBit = `CEH_RECESSIVE;
			default:   driveBit = `CEH_RECESSIVE;
		endcase
	end

	// error flag, wait for recessive, delimiter
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sigState_q <= SIG_IDLE;
			sigCnt_q   <= 3'h0;
			flagDom_q  <= 1'b0;
		end else if (tick_q && node_q == BUS_OFF) begin
			sigState_q <= SIG_IDLE;
			sigCnt_q   <= 3'h0;
		end else if (tick_q) begin
			unique case (sigState_q)
				SIG_IDLE: begin
					if (errNow) begin
						sigState_q <= SIG_FLAG;
						sigCnt_q   <= 3'h0;
						flagDom_q  <= (node_q == ERR_ACTIVE);
					end
				end
				SIG_FLAG: begin
					if (sigCnt_q == `CEH_FLAG_LAST) begin
						sigState_q <= SIG_WAIT;
					end
					sigCnt_q <= sigCnt_q + 3'h1;
				end
				SIG_WAIT: begin
					if (rxSync_q == `CEH_RECESSIVE) begin
						sigState_q <= SIG_DELIM;
						sigCnt_q   <= 3'h0;
					end
				end
				SIG_DELIM: begin
					if (sigCnt_q == `CEH_DELIM_LAST) begin
						sigState_q <= SIG_IDLE;
					end
					sigCnt_q <= sigCnt_q + 3'h1;
				end
			endcase
		end
	end

	// bus driver
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			canTx_q <= `CEH_RECESSIVE;
		end else if (tick_q) begin
			if (node_q == BUS_OFF) begin
				canTx_q <= `CEH_RECESSIVE;
			end else if (errNow) begin
				canTx_q <= (node_q == ERR_ACTIVE) ? `CEH_DOMINANT : `CEH_RECESSIVE;
			end else if (sigState_q == SIG_FLAG && sigCnt_q != `CEH_FLAG_LAST) begin
				canTx_q <= flagDom_q ? `CEH_DOMINANT : `CEH_RECESSIVE;
			end else if (sigState_q != SIG_IDLE) begin
				canTx_q <= `CEH_RECESSIVE;
			end else if (nextStuff && txMode) begin
				canTx_q <= ~rxSync_q;
			end else begin
				canTx_q <= driveBit;
			end
		end
	end

	// bit position tracking and destuffing
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			curField_q <= F_IDLE;
			curStuff_q <= 1'b0;
			curDrive_q <= `CEH_RECESSIVE;
			runCnt_q   <= 3'h0;
			runLast_q  <= `CEH_RECESSIVE;
			crcIdx_q   <= 4'h0;
			bitStep_q  <= 1'b0;
			rxValid_q  <= 1'b0;
			rxBit_q    <= `CEH_RECESSIVE;
		end else begin
			bitStep_q <= 1'b0;
			rxValid_q <= 1'b0;
			if (tick_q && (!normalTick || errNow)) begin
				curField_q <= F_IDLE;
				curStuff_q <= 1'b0;
				curDrive_q <= `CEH_RECESSIVE;
				runCnt_q   <= 3'h0;
				crcIdx_q   <= 4'h0;
			end else if (normalTick) begin
				curField_q <= fieldIn;
				curStuff_q <= nextStuff;
				curDrive_q <= nextStuff ? ~rxSync_q : driveBit;
				runCnt_q   <= isStuffed(curField_q) ? runNext : 3'h0;
				runLast_q  <= rxSync_q;
				bitStep_q  <= !nextStuff && (fieldIn != F_IDLE);
				rxValid_q  <= !curStuff_q && (curField_q != F_IDLE);
				rxBit_q    <= rxSync_q;
				if (fieldIn != F_CRC) begin
					crcIdx_q <= 4'h0;
				end else if (!nextStuff) begin
					crcIdx_q <= crcIdx_q + 4'h1;
				end
			end
		end
	end

	// error counters
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tec_q <= 9'h000;
			rec_q <= 8'h00;
		end else if (recoverDone) begin
			tec_q <= 9'h000;
			rec_q <= 8'h00;
		end else begin
			if (errNow && txMode) begin
				tec_q <= tec_q + `CEH_TX_ERR_STEP;
			end else if (frameEnd && txMode && tec_q != 9'h000) begin
				tec_q <= tec_q - `CEH_TX_OK_STEP;
			end
			if (errNow && !txMode && rec_q != `CEH_REC_MAX) begin
				rec_q <= rec_q + `CEH_RX_ERR_STEP;
			end else if (frameEnd && !txMode && rec_q != 8'h00) begin
				rec_q <= rec_q - `CEH_RX_OK_STEP;
			end
		end
	end

	// node error state
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			node_q <= ERR_ACTIVE;
		end else if (node_q == BUS_OFF) begin
			if (recoverDone) begin
				node_q <= ERR_ACTIVE;
			end
		end else if (tec_q[8]) begin
			node_q <= BUS_OFF;
		end else if (tec_q >= `CEH_PASSIVE_LIMIT || {1'b0, rec_q} >= `CEH_PASSIVE_LIMIT) begin
			node_q <= ERR_PASSIVE;
		end else begin
			node_q <= ERR_ACTIVE;
		end
	end

	// bus-off recovery: runs of eleven recessive bits
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			idleRun_q    <= 4'h0;
			recoverCnt_q <= 8'h00;
		end else if (node_q != BUS_OFF) begin
			idleRun_q    <= 4'h0;
			recoverCnt_q <= 8'h00;
		end else if (tick_q) begin
			if (rxSync_q != `CEH_RECESSIVE) begin
				idleRun_q <= 4'h0;
			end else if (idleRun_q == `CEH_IDLE_LAST) begin
				idleRun_q    <= 4'h0;
				recoverCnt_q <= recoverCnt_q + 8'h01;
			end else begin
				idleRun_q <= idleRun_q + 4'h1;
			end
		end
	end

	// status pulses and bus-ready level
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			errPulse_q <= 1'b0;
			txOk_q     <= 1'b0;
			rxOk_q     <= 1'b0;
			busReady_q <= 1'b0;
		end else begin
			errPulse_q <= errNow;
			txOk_q     <= frameEnd && txMode;
			rxOk_q     <= frameEnd && !txMode;
			busReady_q <= (sigState_q == SIG_IDLE) && (node_q != BUS_OFF) && !errNow;
		end
	end

	assign canTx      = canTx_q;
	assign bitStep    = bitStep_q;
	assign rxValid    = rxValid_q;
	assign rxBit      = rxBit_q;
	assign errPulse   = errPulse_q;
	assign txOk       = txOk_q;
	assign rxOk       = rxOk_q;
	assign busReady   = busReady_q;
	assign nodeState  = node_q;
	assign txErrCount = tec_q;
	assign rxErrCount = rec_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_active_flag: assert property (errNow && node_q == ERR_ACTIVE |=> canTx_q == 1'b0)
		else $error("active flag not dominant");
	a_passive_flag: assert property (errNow && node_q == ERR_PASSIVE |=> canTx_q == 1'b1)
		else $error("passive flag not recessive");
	a_flag_start: assert property (errNow |=> sigState_q == SIG_FLAG && sigCnt_q == 3'h0)
		else $error("flag did not start at once");
	a_flag_end: assert property (tick_q && sigState_q == SIG_FLAG && sigCnt_q == 3'h5 &&
		node_q != BUS_OFF |=> sigState_q == SIG_WAIT && canTx_q == 1'b1)
		else $error("flag not six bits");
	a_delim_end: assert property (tick_q && sigState_q == SIG_DELIM && sigCnt_q == 3'h6 &&
		node_q != BUS_OFF |=> sigState_q == SIG_IDLE)
		else $error("delimiter not seven bits");
	a_tx_step: assert property (errNow && txMode |=> tec_q == $past(tec_q) + 9'h008)
		else $error("transmit error step wrong");
	a_busoff_entry: assert property (tec_q[8] && node_q != BUS_OFF |=> node_q == BUS_OFF)
		else $error("bus-off not entered");
	a_busoff_quiet: assert property (node_q == BUS_OFF ##1 node_q == BUS_OFF && tick_q
		|=> canTx_q == 1'b1)
		else $error("bus-off node drives bus");
	a_passive_state: assert property (!tec_q[8] && node_q != BUS_OFF &&
		(tec_q >= 9'h07f || rec_q >= 8'h7f) |=> node_q == ERR_PASSIVE)
		else $error("passive state not entered");
	a_active_state: assert property (tec_q < 9'h07f && rec_q < 8'h7f && node_q != BUS_OFF
		|=> node_q == ERR_ACTIVE)
		else $error("active state not held");
	a_stuff_insert: assert property (normalTick && !errNow && nextStuff && txMode
		|=> canTx_q != $past(rxSync_q))
		else $error("stuff bit not opposite");
	a_ack_error: assert property (normalTick && txMode && curField_q == F_ACK &&
		rxSync_q == 1'b1 |=> sigState_q == SIG_FLAG)
		else $error("missing ack not flagged");
	a_recover_clear: assert property (recoverDone |=> tec_q == 9'h000 && rec_q == 8'h00 &&
		node_q == ERR_ACTIVE)
		else $error("recovery did not clear");

	c_error_flag: cover property (errNow ##1 sigState_q == SIG_FLAG);
	c_frame_ok: cover property (frameEnd && txMode);
	c_recovered: cover property (recoverDone);

endmodule : ceh_core

`default_nettype wire

// ---- test/ceh_bus_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ceh_defs.svh"

// far-side nodes on the wired-AND bus; a released line floats recessive
module ceh_bus_partner
	import ceh_pkg::*;
(
	input  wire ceh_field_type busField,
	input  wire logic          ackOn,
	input  wire logic          jamOn,
	output var  logic          busDrive
);
	always_comb begin
		busDrive = `CEH_RECESSIVE;
		if (ackOn && busField == F_ACK) begin
			busDrive = `CEH_DOMINANT;
		end
		if (jamOn && busField == F_STUFFED) begin
			busDrive = `CEH_DOMINANT;
		end
	end
endmodule : ceh_bus_partner

`default_nettype wire

// ---- test/can_error_handling_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ceh_defs.svh"

module can_error_handling_tb
	import ceh_pkg::*;
;
	logic          refClk;
	logic          resetN;
	logic          canTx;
	logic          canRx;
	logic          partnerDrive;
	logic          txMode;
	ceh_field_type fieldIn;
	ceh_field_type busField;
	logic          txData;
	logic          ackEn;
	logic          ackOn;
	logic          jamOn;
	logic          bitStep;
	logic          rxValid;
	logic          rxBit;
	logic          errPulse;
	logic          txOk;
	logic          rxOk;
	logic          busReady;
	ceh_node_type  nodeState;
	logic [8:0]    txErrCount;
	logic [7:0]    rxErrCount;
	int            errTotal;
	int            nTests;

	// wired-AND bus: dominant overrides recessive
	assign canRx = canTx & partnerDrive;

	initial begin
		refClk = 1'b0;
		forever #2 refClk = ~refClk;
	end

	ceh_core dut_u (
		.ref_clk    (refClk),
		.reset_n    (resetN),
		.canRx      (canRx),
		.canTx      (canTx),
		.txMode     (txMode),
		.fieldIn    (fieldIn),
		.txData     (txData),
		.ackEn      (ackEn),
		.bitStep    (bitStep),
		.rxValid    (rxValid),
		.rxBit      (rxBit),
		.errPulse   (errPulse),
		.txOk       (txOk),
		.rxOk       (rxOk),
		.busReady   (busReady),
		.nodeState  (nodeState),
		.txErrCount (txErrCount),
		.rxErrCount (rxErrCount)
	);

	ceh_bus_partner partner_u (
		.busField (busField),
		.ackOn    (ackOn),
		.jamOn    (jamOn),
		.busDrive (partnerDrive)
	);

	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		nTests++;
		if (seen !== exp) begin
			errTotal++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic printVerdict;
		if (errTotal == 0 && nTests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : printVerdict

	// sequencer side: present each field until the block takes it
	task automatic run_frame(input int nData, input logic [7:0] data, output logic sawErr,
			output logic sawOk);
		ceh_field_type seq [$];
		int            k;
		int            guard;
		sawErr = 1'b0;
		sawOk  = 1'b0;
		for (k = 0; k < nData; k++) seq.push_back(F_STUFFED);
		repeat (15) seq.push_back(F_CRC);
		seq.push_back(F_CRCDEL);
		seq.push_back(F_ACK);
		seq.push_back(F_ACKDEL);
		repeat (7) seq.push_back(F_EOF);
		k = 0;
		txMode = 1'b1;
		while (k < seq.size() && !sawErr) begin
			fieldIn = seq[k];
			txData  = (k < nData) ? data[k] : 1'b1;
			guard   = 0;
			do begin
				@(negedge refClk);
				guard++;
			end while (!bitStep && !errPulse && guard < 600);
			check("step", {8'h00, guard < 600}, 9'h001);
			if (errPulse) begin
				sawErr = 1'b1;
			end else begin
				busField = seq[k];
				k++;
			end
		end
		if (!sawErr) begin
			fieldIn = F_IDLE;
			for (guard = 0; guard < 600 && !sawOk && !sawErr; guard++) begin
				@(negedge refClk);
				sawOk  = txOk;
				sawErr = errPulse;
			end
			busField = F_IDLE;
			txMode   = 1'b0;
		end
	endtask : run_frame

	// follow one error frame from the cycle of errPulse
	task automatic error_frame(input logic flagLvl, input logic keepJam, input logic [8:0] expTec,
			input logic [7:0] expRec);
		int guard;
		fieldIn = F_IDLE;
		txMode  = 1'b0;
		if (!keepJam) busField = F_IDLE;
		check("flag start", {8'h00, canTx}, {8'h00, flagLvl});
		repeat (1350) @(negedge refClk);
		check("flag held", {8'h00, canTx}, {8'h00, flagLvl});
		busField = F_IDLE;
		repeat (250) @(negedge refClk);
		check("flag end", {8'h00, canTx}, {8'h00, `CEH_RECESSIVE});
		repeat (1300) @(negedge refClk);
		check("delim busy", {8'h00, busReady}, 9'h000);
		for (guard = 0; guard < 3000 && busReady !== 1'b1; guard++) @(negedge refClk);
		check("delim done", {8'h00, busReady}, 9'h001);
		check("tx count", txErrCount, expTec);
		check("rx count", {1'b0, rxErrCount}, {1'b0, expRec});
	endtask : error_frame

	// receiver sees an unbroken recessive run in a stuffed field
	task automatic test_rx_stuff;
		int   guard;
		logic sawBit;
		sawBit  = 1'b0;
		txMode  = 1'b0;
		fieldIn = F_STUFFED;
		for (guard = 0; guard < 3000 && errPulse !== 1'b1; guard++) begin
			@(negedge refClk);
			if (rxValid === 1'b1 && !sawBit) begin
				sawBit = 1'b1;
				check("rx bit", {8'h00, rxBit}, 9'h001);
			end
		end
		check("rx valid", {8'h00, sawBit}, 9'h001);
		check("stuff err", {8'h00, errPulse}, 9'h001);
		error_frame(`CEH_RECESSIVE, 1'b0, 9'h087, 8'h01);
	endtask : test_rx_stuff

	task automatic test_reset;
		check("tx idle", {8'h00, canTx}, 9'h001);
		check("ready rst", {8'h00, busReady}, 9'h000);
		check("state rst", {7'h00, nodeState}, {7'h00, ERR_ACTIVE});
		check("tec rst", txErrCount, 9'h000);
		resetN = 1'b1;
		repeat (2) @(negedge refClk);
		check("ready", {8'h00, busReady}, 9'h001);
	endtask : test_reset

	task automatic test_no_ack;
		logic e;
		logic o;
		ackOn = 1'b0;
		run_frame(4, 8'h0a, e, o);
		check("ack err", {8'h00, e}, 9'h001);
		check("ack slot", {6'h00, busField}, {6'h00, F_ACK});
		error_frame(`CEH_DOMINANT, 1'b0, 9'h008, 8'h00);
	endtask : test_no_ack

	task automatic test_bit_errors;
		logic e;
		logic o;
		int   i;
		jamOn = 1'b1;
		for (i = 2; i <= 16; i++) begin
			run_frame(2, 8'h02, e, o);
			check("bit err", {8'h00, e}, 9'h001);
			error_frame(`CEH_DOMINANT, 1'b0, 9'(8 * i), 8'h00);
			check("state", {7'h00, nodeState},
				{7'h00, (8 * i >= 127) ? ERR_PASSIVE : ERR_ACTIVE});
		end
		jamOn = 1'b0;
	endtask : test_bit_errors

	// dominant bus during a passive flag must not add a second error
	task automatic test_passive_flag;
		logic e;
		logic o;
		jamOn = 1'b1;
		run_frame(2, 8'h02, e, o);
		check("pas err", {8'h00, e}, 9'h001);
		error_frame(`CEH_RECESSIVE, 1'b1, 9'h088, 8'h00);
		jamOn = 1'b0;
	endtask : test_passive_flag

	task automatic test_good_frame;
		logic e;
		logic o;
		ackOn = 1'b1;
		run_frame(4, 8'h0a, e, o);
		check("ok err", {8'h00, e}, 9'h000);
		check("ok pulse", {8'h00, o}, 9'h001);
		repeat (4) @(negedge refClk);
		check("tec dec", txErrCount, 9'h087);
		check("state pas", {7'h00, nodeState}, {7'h00, ERR_PASSIVE});
		ackOn = 1'b0;
	endtask : test_good_frame

	initial begin
		errTotal = 0;
		nTests   = 0;
		resetN   = 1'b0;
		txMode   = 1'b0;
		fieldIn  = F_IDLE;
		busField = F_IDLE;
		txData   = 1'b1;
		ackEn    = 1'b0;
		ackOn    = 1'b0;
		jamOn    = 1'b0;
		repeat (16) @(negedge refClk);
		test_reset();
		test_no_ack();
		test_bit_errors();
		test_passive_flag();
		test_good_frame();
		test_rx_stuff();
		printVerdict();
	end

	// watchdog sized for about 90k cycles of traffic
	initial begin
		repeat (99000) @(posedge refClk);
		errTotal++;
		printVerdict();
	end
endmodule : can_error_handling_tb

`default_nettype wire
